// ==== design/rip_pins.sv ====
`timescale 1ns/10ps
module rip_pins #(
    parameter int WD_PULSE_CYCLES = rip_pkg::WD_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Register port
    input  wire logic [rip_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [rip_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [rip_pkg::DATA_W-1:0] rdata_o,
    output logic                           irq_o,
    // System reset pin and core control
    input  wire logic                      system_reset_n_i,
    output logic                           system_reset_n_o,
    output logic                           system_reset_n_oe_o,
    input  wire logic                      watchdog_overflow_i,
    output logic                           exec_enable_o,
    output logic                           program_counter_clear_o,
    output logic                           fetch_start_o,
    // Drive fault inputs and PWM tri-state
    input  wire logic                      drive_fault_a_n_i,
    input  wire logic                      drive_fault_b_n_i,
    output logic                           pwm_a_hiz_o,
    output logic                           pwm_b_hiz_o,
    // User interrupt pins with port functions
    input  wire logic                      user_irq_1_i,
    output logic                           user_irq_1_o,
    output logic                           user_irq_1_oe_o,
    input  wire logic                      user_irq_2_i,
    output logic                           user_irq_2_o,
    output logic                           user_irq_2_oe_o,
    output logic                           conv_start_trigger_o,
    // Clock output pin
    input  wire logic                      watchdog_clock_i,
    input  wire logic                      cpu_clock_out_i,
    output logic                           cpu_clock_out_o,
    output logic                           cpu_clock_out_oe_o,
    // Oscillator pins
    input  wire logic                      osc_in_i,
    input  wire logic                      emulation_off_n_i,
    output logic                           osc_out_o,
    output logic                           osc_out_oe_o
);
    if (WD_PULSE_CYCLES < 1 || WD_PULSE_CYCLES > 255) begin : g_bad_pulse
        $error("WD_PULSE_CYCLES must lie in 1..255");
    end

    localparam logic [rip_pkg::WD_CNT_W-1:0] WD_LEN = WD_PULSE_CYCLES[rip_pkg::WD_CNT_W-1:0];

    // Synchronised pins
    rip_sync_if #(.N(rip_pkg::SYNC_N)) sy ();

    rip_sync_edge #(
        .N (rip_pkg::SYNC_N)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .sy      (sy)
    );

    logic [rip_pkg::DATA_W-1:0] sys_ctrl_reg;
    logic [rip_pkg::GPIO_W-1:0] gpio_dir_reg;
    logic [rip_pkg::GPIO_W-1:0] gpio_out_reg;
    logic [rip_pkg::EV_W-1:0]   irq_stat_reg;
    logic [rip_pkg::EV_W-1:0]   irq_en_reg;
    logic [rip_pkg::WD_CNT_W-1:0] wd_cnt_reg;
    rip_pkg::rip_rst_e          state_reg;
    rip_pkg::rip_rst_e          state_next;
    logic                       clk_div_reg;

    assign sy.raw = {osc_in_i, watchdog_clock_i, emulation_off_n_i, system_reset_n_i,
                     cpu_clock_out_i, user_irq_2_i, user_irq_1_i,
                     drive_fault_b_n_i, drive_fault_a_n_i};
    assign sy.rise_sel = {5'h00,
                          sys_ctrl_reg[rip_pkg::IRQ2_RISE_BIT],
                          sys_ctrl_reg[rip_pkg::IRQ1_RISE_BIT],
                          2'h0};

    wire core_hold = !rst_n_i || !sy.level[rip_pkg::SY_RST_PIN];

    wire wr_ctrl = wr_i && (addr_i == rip_pkg::ADDR_SYS_CTRL);
    wire wr_dir  = wr_i && (addr_i == rip_pkg::ADDR_GPIO_DIR);
    wire wr_out  = wr_i && (addr_i == rip_pkg::ADDR_GPIO_OUT);
    wire wr_clr  = wr_i && (addr_i == rip_pkg::ADDR_IRQ_CLR);
    wire wr_en   = wr_i && (addr_i == rip_pkg::ADDR_IRQ_EN);

    wire [rip_pkg::EV_W-1:0] ev_hit = {sy.edge_hit[rip_pkg::SY_IRQ2],
                                       sy.edge_hit[rip_pkg::SY_IRQ1],
                                       sy.edge_hit[rip_pkg::SY_FAULT_B],
                                       sy.edge_hit[rip_pkg::SY_FAULT_A]};
    wire [rip_pkg::EV_W-1:0] irq_stat_next =
        ev_hit | (irq_stat_reg & ~(wr_clr ? wdata_i[rip_pkg::EV_W-1:0] : 4'h0));

    wire [rip_pkg::GPIO_W-1:0] gpio_in = {sy.level[rip_pkg::SY_PORT_E0],
                                          sy.level[rip_pkg::SY_IRQ2],
                                          sy.level[rip_pkg::SY_IRQ1]};

    wire [rip_pkg::DATA_W-1:0] read_mux =
        (addr_i == rip_pkg::ADDR_SYS_CTRL) ? sys_ctrl_reg :
        (addr_i == rip_pkg::ADDR_GPIO_DIR) ? {13'h0000, gpio_dir_reg} :
        (addr_i == rip_pkg::ADDR_GPIO_OUT) ? {13'h0000, gpio_out_reg} :
        (addr_i == rip_pkg::ADDR_GPIO_IN)  ? {13'h0000, gpio_in} :
        (addr_i == rip_pkg::ADDR_IRQ_STAT) ? {12'h000, irq_stat_reg} :
        (addr_i == rip_pkg::ADDR_IRQ_EN)   ? {12'h000, irq_en_reg} :
        16'h0000;

    // Register file
    always_ff @(posedge clk_i) begin
        if (core_hold) begin
            sys_ctrl_reg <= rip_pkg::SYS_CTRL_RST;
            gpio_dir_reg <= rip_pkg::GPIO_DIR_RST;
            gpio_out_reg <= rip_pkg::GPIO_OUT_RST;
            irq_stat_reg <= rip_pkg::EV_RST;
            irq_en_reg   <= rip_pkg::EV_RST;
        end else begin
            if (wr_ctrl) begin
                sys_ctrl_reg <= wdata_i & rip_pkg::SYS_CTRL_MASK;
            end
            if (wr_dir) begin
                gpio_dir_reg <= wdata_i[rip_pkg::GPIO_W-1:0];
            end
            if (wr_out) begin
                gpio_out_reg <= wdata_i[rip_pkg::GPIO_W-1:0];
            end
            if (wr_en) begin
                irq_en_reg <= wdata_i[rip_pkg::EV_W-1:0];
            end
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? read_mux : 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (core_hold) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_next & irq_en_reg);
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rip_pkg::ST_HELD: begin
                state_next = rip_pkg::ST_RESTART;
            end
            rip_pkg::ST_RESTART: begin
                state_next = rip_pkg::ST_RUN;
            end
            rip_pkg::ST_RUN: begin
                state_next = rip_pkg::ST_RUN;
            end
            default: begin
                state_next = rip_pkg::ST_HELD;
            end
        endcase
        if (core_hold) begin
            state_next = rip_pkg::ST_HELD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg               <= rip_pkg::ST_HELD;
            exec_enable_o           <= 1'b0;
            program_counter_clear_o <= 1'b1;
            fetch_start_o           <= 1'b0;
        end else begin
            state_reg               <= state_next;
            exec_enable_o           <= (state_next == rip_pkg::ST_RUN);
            program_counter_clear_o <= (state_next == rip_pkg::ST_HELD);
            fetch_start_o           <= (state_next == rip_pkg::ST_RESTART);
        end
    end

    // watchdog reset pulse onto the pin
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wd_cnt_reg          <= 8'h00;
            system_reset_n_oe_o <= 1'b0;
        end else begin
            if (watchdog_overflow_i) begin
                wd_cnt_reg <= WD_LEN;
            end else if (wd_cnt_reg != 8'h00) begin
                wd_cnt_reg <= wd_cnt_reg - 8'h01;
            end
            system_reset_n_oe_o <= watchdog_overflow_i || (wd_cnt_reg > 8'h01);
        end
    end

    always_ff @(posedge clk_i) begin
        system_reset_n_o <= 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (core_hold) begin
            pwm_a_hiz_o <= 1'b0;
            pwm_b_hiz_o <= 1'b0;
        end else begin
            pwm_a_hiz_o <= irq_stat_next[rip_pkg::EV_FAULT_A];
            pwm_b_hiz_o <= irq_stat_next[rip_pkg::EV_FAULT_B];
        end
    end

    // port A bit 2 on irq 1 pin
    // port D bit 0 and start trigger
    always_ff @(posedge clk_i) begin
        if (core_hold) begin
            user_irq_1_o         <= 1'b0;
            user_irq_1_oe_o      <= 1'b0;
            user_irq_2_o         <= 1'b0;
            user_irq_2_oe_o      <= 1'b0;
            conv_start_trigger_o <= 1'b0;
        end else begin
            user_irq_1_o         <= gpio_out_reg[rip_pkg::GPIO_A2_BIT];
            user_irq_1_oe_o      <= gpio_dir_reg[rip_pkg::GPIO_A2_BIT];
            user_irq_2_o         <= gpio_out_reg[rip_pkg::GPIO_D0_BIT];
            user_irq_2_oe_o      <= gpio_dir_reg[rip_pkg::GPIO_D0_BIT];
            conv_start_trigger_o <= sy.edge_hit[rip_pkg::SY_IRQ2];
        end
    end

    // port E bit 0 when clock off
    wire clk_func = sys_ctrl_reg[rip_pkg::CLK_FUNC_BIT];
    wire clk_src  = sys_ctrl_reg[rip_pkg::CLK_SEL_BIT] ? sy.level[rip_pkg::SY_WD_CLK]
                                                        : clk_div_reg;
    always_ff @(posedge clk_i) begin
        if (core_hold) begin
            clk_div_reg        <= 1'b0;
            cpu_clock_out_o    <= 1'b0;
            cpu_clock_out_oe_o <= 1'b0;
        end else begin
            clk_div_reg        <= ~clk_div_reg;
            cpu_clock_out_o    <= clk_func ? clk_src : gpio_out_reg[rip_pkg::GPIO_E0_BIT];
            cpu_clock_out_oe_o <= clk_func || gpio_dir_reg[rip_pkg::GPIO_E0_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            osc_out_o    <= 1'b0;
            osc_out_oe_o <= 1'b0;
        end else begin
            osc_out_o    <= ~sy.level[rip_pkg::SY_OSC_IN];
            osc_out_oe_o <= sy.level[rip_pkg::SY_EMU_OFF];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_hold_release;
        core_hold ##1 !core_hold;
    endsequence

    sequence s_restart;
        fetch_start_o && !exec_enable_o ##1 exec_enable_o && !fetch_start_o;
    endsequence

    reset_halt_a: assert property (
        core_hold |=> !exec_enable_o && program_counter_clear_o)
        else $error("core not halted during reset");

    restart_seq_a: assert property (
        s_hold_release |=> s_restart)
        else $error("restart sequence wrong after reset release");

    regs_zero_a: assert property (
        core_hold |=> sys_ctrl_reg == 16'h0000 && irq_stat_reg == 4'h0 && !irq_o)
        else $error("registers not cleared by reset");

    wd_pulse_a: assert property (
        watchdog_overflow_i |=> system_reset_n_oe_o)
        else $error("watchdog did not drive reset pin");

    open_drain_a: assert property (
        ##1 !system_reset_n_o)
        else $error("reset pin driven high");

    fault_a_hiz_a: assert property (
        $fell(sy.level[rip_pkg::SY_FAULT_A]) && !core_hold ##1 !core_hold && !wr_clr
        |-> pwm_a_hiz_o [*2])
        else $error("fault A edge did not tri-state PWM A");

    fault_b_hiz_a: assert property (
        $fell(sy.level[rip_pkg::SY_FAULT_B]) && !core_hold |=> pwm_b_hiz_o)
        else $error("fault B edge did not tri-state PWM B");

    irq1_pend_a: assert property (
        sy.edge_hit[rip_pkg::SY_IRQ1] && !core_hold |=> irq_stat_reg[rip_pkg::EV_IRQ1])
        else $error("irq 1 edge not pending");

    conv_trig_a: assert property (
        sy.edge_hit[rip_pkg::SY_IRQ2] && !core_hold |=> conv_start_trigger_o)
        else $error("irq 2 edge did not start conversion");

    clk_wd_sel_a: assert property (
        clk_func && sys_ctrl_reg[rip_pkg::CLK_SEL_BIT] && !core_hold
        |=> cpu_clock_out_o == $past(sy.level[rip_pkg::SY_WD_CLK]) && cpu_clock_out_oe_o)
        else $error("clock pin not carrying watchdog clock");

    osc_hiz_a: assert property (
        !sy.level[rip_pkg::SY_EMU_OFF] |=> !osc_out_oe_o)
        else $error("crystal output driven while emulation off low");

    gpio_input_a: assert property (
        core_hold |=> !user_irq_1_oe_o && !user_irq_2_oe_o && !cpu_clock_out_oe_o)
        else $error("port pin left driving after reset");

    pend_hold_a: assert property (
        irq_stat_reg[rip_pkg::EV_IRQ2] && !wr_clr && !core_hold
        |=> irq_stat_reg[rip_pkg::EV_IRQ2])
        else $error("pending flag lost without a clear");
endmodule

// ==== design/rip_pkg.sv ====
package rip_pkg;
    // Register bus shape
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // Register offsets (word index on the plain port)
    localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_DIR = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_OUT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_IN  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 4'h6;

    // system_control_status fields
    localparam int CLK_FUNC_BIT  = 0;
    localparam int IRQ1_RISE_BIT = 1;
    localparam int IRQ2_RISE_BIT = 2;
    localparam int CLK_SEL_BIT   = 14;
    localparam logic [DATA_W-1:0] SYS_CTRL_MASK = 16'h4007;
    localparam logic [DATA_W-1:0] SYS_CTRL_RST  = 16'h0000;

    // General-purpose pin bits
    localparam int GPIO_W      = 3;
    localparam int GPIO_A2_BIT = 0;
    localparam int GPIO_D0_BIT = 1;
    localparam int GPIO_E0_BIT = 2;
    localparam logic [GPIO_W-1:0] GPIO_DIR_RST = 3'h0;
    localparam logic [GPIO_W-1:0] GPIO_OUT_RST = 3'h0;

    // Event bits of status, clear and enable
    localparam int EV_W          = 4;
    localparam int EV_FAULT_A    = 0;
    localparam int EV_FAULT_B    = 1;
    localparam int EV_IRQ1       = 2;
    localparam int EV_IRQ2       = 3;
    localparam logic [EV_W-1:0] EV_RST = 4'h0;

    // Synchroniser lanes
    localparam int SYNC_N      = 9;
    localparam int SY_FAULT_A  = 0;
    localparam int SY_FAULT_B  = 1;
    localparam int SY_IRQ1     = 2;
    localparam int SY_IRQ2     = 3;
    localparam int SY_PORT_E0  = 4;
    localparam int SY_RST_PIN  = 5;
    localparam int SY_EMU_OFF  = 6;
    localparam int SY_WD_CLK   = 7;
    localparam int SY_OSC_IN   = 8;

    // Length of the reset pulse driven out after a watchdog overflow
    localparam int WD_PULSE_CYCLES = 8;
    localparam int WD_CNT_W        = 8;

    typedef enum logic [1:0] {
        ST_HELD    = 2'b00,
        ST_RESTART = 2'b01,
        ST_RUN     = 2'b10
    } rip_rst_e;
endpackage

// ==== design/rip_sync_edge.sv ====
`timescale 1ns/10ps
module rip_sync_edge #(
    parameter int N = 9
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Pin lanes
    rip_sync_if.det   sy
);
    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] prev_reg;

    // Pins idle high behind their pullups
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end else begin
            meta_reg <= sy.raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign sy.level    = sync_reg;
    assign sy.edge_hit = (sy.rise_sel & sync_reg & ~prev_reg)
                       | (~sy.rise_sel & ~sync_reg & prev_reg);
endmodule

// ==== design/rip_sync_if.sv ====
`timescale 1ns/10ps
interface rip_sync_if #(
    parameter int N = 9
);
    logic [N-1:0] raw;
    logic [N-1:0] rise_sel;
    logic [N-1:0] level;
    logic [N-1:0] edge_hit;

    modport det (
        input  raw,
        input  rise_sel,
        output level,
        output edge_hit
    );
    modport user (
        output raw,
        output rise_sel,
        input  level,
        input  edge_hit
    );
endinterface

// ==== tb/rip_far.sv ====
`timescale 1ns/10ps
module rip_far (
    // Clock
    input  wire logic clk_i,
    // Requests from the bench
    input  wire logic ext_rst_i,
    input  wire logic fault_a_i,
    input  wire logic fault_b_i,
    // Device pull on the reset pin
    input  wire logic dev_pull_i,
    // Pin levels
    output logic      rst_pin_o,
    output logic      fault_a_n_o,
    output logic      fault_b_n_o
);
    logic ext_q = 1'b0;
    logic fa_q  = 1'b0;
    logic fb_q  = 1'b0;
    assign rst_pin_o = ~(ext_q | dev_pull_i);
    assign fault_a_n_o = ~fa_q;
    assign fault_b_n_o = ~fb_q;
    always @(posedge clk_i) begin
        ext_q <= ext_rst_i;
        fa_q  <= fault_a_i;
        fb_q  <= fault_b_i;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    localparam int WD_N = 6;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ovf = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, d;
    logic [2:0]  drv = 3'h7, dir, out;
    logic        ext_rst = 1'b0, fa = 1'b0, fb = 1'b0, watchdog_clock = 1'b0, osc = 1'b0, emu = 1'b1;
    logic [31:0] seed = 32'hbe6f204a;
    int          n_mismatch = 0, check_count = 0, trig_n = 0, n;
    logic        prev;
    wire logic [15:0] rdata_o;
    wire logic irq_o, rs_o, rs_oe, exec_o, pcclr_o, fetch_o, hiz_a, hiz_b, conv_o;
    wire logic fa_n, fb_n, rs_pin, u1_o, u1_oe, u2_o, u2_oe, ck_o, ck_oe, osc_o, osc_oe;
    wire logic [2:0] oe_v = {ck_oe, u2_oe, u1_oe};
    wire logic [2:0] o_v = {ck_o, u2_o, u1_o};
    wire logic [2:0] pin = (oe_v & o_v) | (~oe_v & drv);
    wire logic [3:0] watch = {fetch_o, hiz_b, hiz_a, irq_o};

    always #2.5 clk_i = ~clk_i;

    rip_far rip_far_i (.clk_i(clk_i), .ext_rst_i(ext_rst), .fault_a_i(fa), .fault_b_i(fb),
        .dev_pull_i(rs_oe & ~rs_o), .rst_pin_o(rs_pin), .fault_a_n_o(fa_n), .fault_b_n_o(fb_n));
    rip_pins #(.WD_PULSE_CYCLES(WD_N)) rip_pins_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .system_reset_n_i(rs_pin), .system_reset_n_o(rs_o),
        .system_reset_n_oe_o(rs_oe), .watchdog_overflow_i(ovf), .exec_enable_o(exec_o),
        .program_counter_clear_o(pcclr_o), .fetch_start_o(fetch_o),
        .drive_fault_a_n_i(fa_n), .drive_fault_b_n_i(fb_n), .pwm_a_hiz_o(hiz_a),
        .pwm_b_hiz_o(hiz_b), .user_irq_1_i(pin[0]), .user_irq_1_o(u1_o),
        .user_irq_1_oe_o(u1_oe), .user_irq_2_i(pin[1]), .user_irq_2_o(u2_o),
        .user_irq_2_oe_o(u2_oe), .conv_start_trigger_o(conv_o), .watchdog_clock_i(watchdog_clock),
        .cpu_clock_out_i(pin[2]), .cpu_clock_out_o(ck_o), .cpu_clock_out_oe_o(ck_oe),
        .osc_in_i(osc), .emulation_off_n_i(emu), .osc_out_o(osc_o), .osc_out_oe_o(osc_oe));

    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic logic [15:0] lvl(logic [2:0] di, logic [2:0] ou, logic [2:0] dr);
        return {13'h0000, (di & ou) | (~di & dr)};
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_bit(string what, logic exp, logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0b seen %0b", what, exp, got);
        end
    endtask

    task automatic chk_w(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits k edges, counting conversion trigger pulses
    task automatic cyc(int k);
        repeat (k) begin
            @(posedge clk_i);
            #1;
            if (conv_o === 1'b1) trig_n++;
        end
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd_chk(string what, logic [3:0] a, logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk_w(what, exp, rdata_o);
    endtask

    task automatic wait_bit(int k);
        int i;
        i = 0;
        while (watch[k] !== 1'b1 && i < 40) begin
            cyc(1);
            i++;
        end
        if (i == 40) begin
            n_mismatch++;
            $display("wrong value wait %0d expected 1 seen 0", k);
            final_report();
        end
    endtask

    task automatic wait_fetch();
        wait_bit(3);
        cyc(1);
        chk_bit("exec", 1'b1, exec_o);
        chk_bit("pc clear", 1'b0, pcclr_o);
    endtask

    initial begin
        repeat (15) @(posedge clk_i);
        #1;
        chk_bit("pc clear", 1'b1, pcclr_o);
        chk_bit("exec", 1'b0, exec_o);
        chk_w("pin oe", 16'h0000, {13'h0000, oe_v});
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_fetch();
        rd_chk("sys ctrl", rip_pkg::ADDR_SYS_CTRL, 16'h0000);
        rd_chk("status", rip_pkg::ADDR_IRQ_STAT, 16'h0000);
        rd_chk("unmapped", 4'hf, 16'h0000);
        $display("test reset done");
        for (int t = 0; t < 6; t++) begin
            seed = xs(seed);
            {out, dir} = seed[5:0];
            drv <= seed[8:6];
            wr(rip_pkg::ADDR_GPIO_DIR, {13'h0000, dir});
            wr(rip_pkg::ADDR_GPIO_OUT, {13'h0000, out});
            cyc(4);
            chk_w("pin oe", {13'h0000, dir}, {13'h0000, oe_v});
            chk_w("pin out", {13'h0000, dir & out}, {13'h0000, o_v & dir});
            rd_chk("gpio in", rip_pkg::ADDR_GPIO_IN, lvl(dir, out, drv));
        end
        wr(rip_pkg::ADDR_GPIO_DIR, 16'h0000);
        // Back to pulled-up idle, then drop edges left by the random pins
        drv <= 3'h7;
        cyc(6);
        wr(rip_pkg::ADDR_IRQ_CLR, 16'h000f);
        $display("test gpio done");
        fa <= 1'b1;
        wait_bit(1);
        chk_bit("hiz b", 1'b0, hiz_b);
        rd_chk("status", rip_pkg::ADDR_IRQ_STAT, 16'h0001);
        fa <= 1'b0;
        fb <= 1'b1;
        wait_bit(2);
        rd_chk("status", rip_pkg::ADDR_IRQ_STAT, 16'h0003);
        wr(rip_pkg::ADDR_IRQ_CLR, 16'h0003);
        fb <= 1'b0;
        cyc(6);
        chk_w("hiz", 16'h0000, {14'h0000, hiz_b, hiz_a});
        rd_chk("status", rip_pkg::ADDR_IRQ_STAT, 16'h0000);
        $display("test fault done");
        for (int k = 0; k < 4; k++) begin
            wr(rip_pkg::ADDR_IRQ_EN, 16'h000f);
            wr(rip_pkg::ADDR_SYS_CTRL, {13'h0000, k[0] & k[1], k[0] & ~k[1], 1'b0});
            drv[k[1]] <= k[0];
            cyc(6);
            wr(rip_pkg::ADDR_IRQ_CLR, 16'h000f);
            trig_n = 0;
            drv[k[1]] <= ~k[0];
            cyc(6);
            chk_bit("irq wrong edge", 1'b0, irq_o);
            chk_w("trigger count", 16'h0000, trig_n[15:0]);
            drv[k[1]] <= k[0];
            wait_bit(0);
            cyc(3);
            rd_chk("status", rip_pkg::ADDR_IRQ_STAT, 16'h0004 << k[1]);
            chk_w("trigger count", {15'h0000, k[1]}, trig_n[15:0]);
            wr(rip_pkg::ADDR_IRQ_EN, 16'h0000);
            cyc(2);
            chk_bit("irq masked", 1'b0, irq_o);
            wr(rip_pkg::ADDR_IRQ_CLR, 16'h000f);
        end
        $display("test irq done");
        wr(rip_pkg::ADDR_SYS_CTRL, 16'h0001);
        cyc(3);
        chk_bit("clock oe", 1'b1, ck_oe);
        prev = ck_o;
        cyc(1);
        chk_bit("cpu clock", ~prev, ck_o);
        wr(rip_pkg::ADDR_SYS_CTRL, 16'h4001);
        watchdog_clock <= 1'b1;
        cyc(5);
        chk_bit("wd clock", 1'b1, ck_o);
        watchdog_clock <= 1'b0;
        cyc(5);
        chk_bit("wd clock", 1'b0, ck_o);
        wr(rip_pkg::ADDR_SYS_CTRL, 16'h0000);
        chk_w("osc", 16'h0003, {14'h0000, osc_oe, osc_o});
        osc <= 1'b1;
        emu <= 1'b0;
        cyc(5);
        chk_bit("osc oe", 1'b0, osc_oe);
        emu <= 1'b1;
        cyc(5);
        chk_w("osc", 16'h0002, {14'h0000, osc_oe, osc_o});
        $display("test clock done");
        wr(rip_pkg::ADDR_IRQ_EN, 16'h000f);
        ovf <= 1'b1;
        @(posedge clk_i);
        ovf <= 1'b0;
        #1;
        n = 0;
        while (rs_oe === 1'b1 && n < 40) begin
            if (n == 0) chk_bit("reset pin out", 1'b0, rs_o);
            if (n == 4) chk_w("held", 16'h0001, {14'h0000, exec_o, pcclr_o});
            n++;
            cyc(1);
        end
        chk_w("pulse length", WD_N[15:0], n[15:0]);
        wait_fetch();
        rd_chk("enable", rip_pkg::ADDR_IRQ_EN, 16'h0000);
        ext_rst <= 1'b1;
        cyc(6);
        chk_w("held", 16'h0001, {14'h0000, exec_o, pcclr_o});
        chk_bit("reset pin oe", 1'b0, rs_oe);
        ext_rst <= 1'b0;
        wait_fetch();
        $display("test reset pin done");
        final_report();
    end
endmodule
